//--- logic/tmr_pkg.sv
// Constants and types shared by the first timer count and control block
package tmr_pkg;
  // -------------------------------------------------------------------------
  // Register map (indices; byte address is four times the index)
  // -------------------------------------------------------------------------
  localparam logic [5:0] TMR_IDX_COUNT = 6'h00;
  localparam logic [5:0] TMR_IDX_CTRL = 6'h01;
  localparam logic [5:0] TMR_IDX_RUN = 6'h02;
  localparam logic [5:0] TMR_IDX_LAST = 6'h3b;
  localparam int TMR_ADDR_W = 8;
  localparam logic [1:0] TMR_RESP_OKAY = 2'h0;
  localparam logic [1:0] TMR_RESP_DECERR = 2'h3;
  // -------------------------------------------------------------------------
  // Control register fields and reset values
  // -------------------------------------------------------------------------
  localparam int TMR_SEL_LSB = 0;
  localparam int TMR_RELOAD_BIT = 4;
  localparam int TMR_TONE_BIT = 5;
  localparam logic [3:0] TMR_SEL_RESET = 4'he;
  localparam logic TMR_RELOAD_RESET = 1'h1;
  localparam logic TMR_TONE_RESET = 1'h1;
  localparam int TMR_RUN_BIT = 0;
  // -------------------------------------------------------------------------
  // Clock select codes and divider tap positions
  // -------------------------------------------------------------------------
  localparam logic [3:0] TMR_SEL_EXT0 = 4'h0;
  localparam logic [3:0] TMR_SEL_EXT1 = 4'h1;
  localparam logic [3:0] TMR_SEL_S13A = 4'h2;
  localparam logic [3:0] TMR_SEL_S13B = 4'h3;
  localparam logic [3:0] TMR_SEL_S11 = 4'h4;
  localparam logic [3:0] TMR_SEL_S9 = 4'h5;
  localparam logic [3:0] TMR_SEL_S7 = 4'h6;
  localparam logic [3:0] TMR_SEL_S5 = 4'h7;
  localparam logic [3:0] TMR_SEL_F6 = 4'h8;
  localparam logic [3:0] TMR_SEL_F0 = 4'he;
  localparam logic [3:0] TMR_SEL_FAST = 4'hf;
  localparam int TMR_SLOW_W = 14;
  localparam int TMR_FAST_W = 7;
  localparam int TMR_TAP_S13 = 13;
  localparam int TMR_TAP_S11 = 11;
  localparam int TMR_TAP_S9 = 9;
  localparam int TMR_TAP_S7 = 7;
  localparam int TMR_TAP_S5 = 5;
  localparam int TMR_TAP_F6 = 6;

  typedef struct packed {
    logic toneEn;
    logic reloadMode;
    logic [3:0] clkSel;
  } tmr_ctrl_t;

  localparam tmr_ctrl_t TMR_CTRL_RESET = '{toneEn: TMR_TONE_RESET,
    reloadMode: TMR_RELOAD_RESET, clkSel: TMR_SEL_RESET};
endpackage

//--- logic/tmr_first_timer.sv
// First 8-bit timer: count/preload and control registers behind AXI4-Lite
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
`timescale 1ns/10ps
module tmr_first_timer import tmr_pkg::*; #(
  parameter int COUNT_W = 8
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic slowOscTick,
  input wire logic externalCountInput,
  output logic toneOutputFirst,
  output logic counterOverflow,
  input wire logic [TMR_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [TMR_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  if (COUNT_W < 1 || COUNT_W > 32) begin : g_chk
    $error("COUNT_W must be 1..32");
  end

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  logic [TMR_ADDR_W-1:0] awAddr_reg, awAddr_next;
  logic awHave_reg, awHave_next;
  logic [31:0] wData_reg, wData_next;
  logic wByte0_reg, wByte0_next;
  logic wHave_reg, wHave_next;
  logic bValid_reg, bValid_next;
  logic [1:0] bResp_reg, bResp_next;
  logic rValid_reg, rValid_next;
  logic [1:0] rResp_reg, rResp_next;
  logic [31:0] rData_reg, rData_next;
  tmr_ctrl_t ctrl_reg, ctrl_next;
  logic run_reg, run_next;
  logic [COUNT_W-1:0] count_reg, count_next;
  logic [COUNT_W-1:0] preload_reg, preload_next;
  logic [TMR_SLOW_W-1:0] slowChain_reg, slowChain_next;
  logic [TMR_FAST_W-1:0] fastChain_reg, fastChain_next;
  logic extPrev_reg, extPrev_next;
  logic tone_reg, tone_next;
  logic ovf_reg, ovf_next;

  // ---------------------------------------------------------------------------
  // Divider taps: tap k pulses once per 2^(k+1) input edges
  // ---------------------------------------------------------------------------
  logic [TMR_SLOW_W-1:0] slowTap;
  logic [TMR_FAST_W-1:0] fastTap;
  logic countTick;
  logic doWrite;
  logic [5:0] wIdx;
  logic [5:0] rIdx;
  logic wInRange;
  logic rInRange;

  for (genvar k = 0; k < TMR_SLOW_W; k++) begin : g_slowTap
    assign slowTap[k] = slowOscTick && (&slowChain_reg[k:0]);
  end
  for (genvar k = 0; k < TMR_FAST_W; k++) begin : g_fastTap
    assign fastTap[k] = &fastChain_reg[k:0];
  end

  // ---------------------------------------------------------------------------
  // Count clock selection
  // ---------------------------------------------------------------------------
  always_comb begin
    case (ctrl_reg.clkSel)
      TMR_SEL_EXT0, TMR_SEL_EXT1: countTick = externalCountInput && !extPrev_reg;
      TMR_SEL_S13A, TMR_SEL_S13B: countTick = slowTap[TMR_TAP_S13];
      TMR_SEL_S11: countTick = slowTap[TMR_TAP_S11];
      TMR_SEL_S9: countTick = slowTap[TMR_TAP_S9];
      TMR_SEL_S7: countTick = slowTap[TMR_TAP_S7];
      TMR_SEL_S5: countTick = slowTap[TMR_TAP_S5];
      TMR_SEL_FAST: countTick = 1'b1;
      default: begin
        // Codes 1000..1110 walk the fast taps downward from tap 6
        countTick = fastTap[TMR_TAP_F6 - int'(ctrl_reg.clkSel - TMR_SEL_F6)];
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------
  always_comb begin
    wIdx = awAddr_reg[7:2];
    rIdx = s_axi_araddr[7:2];
    // Only word-aligned addresses inside the block's window are answered OKAY
    wInRange = (awAddr_reg[1:0] == 2'h0) && (wIdx <= TMR_IDX_LAST);
    rInRange = (s_axi_araddr[1:0] == 2'h0) && (rIdx <= TMR_IDX_LAST);
    doWrite = awHave_reg && wHave_reg && !bValid_reg;
  end

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    awAddr_next = awAddr_reg;
    awHave_next = awHave_reg;
    wData_next = wData_reg;
    wByte0_next = wByte0_reg;
    wHave_next = wHave_reg;
    bValid_next = bValid_reg;
    bResp_next = bResp_reg;

    if (s_axi_awvalid && s_axi_awready) begin
      awAddr_next = s_axi_awaddr;
      awHave_next = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wData_next = s_axi_wdata;
      wByte0_next = s_axi_wstrb[0];
      wHave_next = 1'b1;
    end
    if (bValid_reg && s_axi_bready) begin
      bValid_next = 1'b0;
    end
    if (doWrite) begin
      awHave_next = 1'b0;
      wHave_next = 1'b0;
      bValid_next = 1'b1;
      bResp_next = wInRange ? TMR_RESP_OKAY : TMR_RESP_DECERR;
    end
  end

  always_comb begin
    ctrl_next = ctrl_reg;
    run_next = run_reg;
    count_next = count_reg;
    preload_next = preload_reg;
    tone_next = tone_reg;
    ovf_next = 1'b0;
    extPrev_next = externalCountInput;
    fastChain_next = fastChain_reg + 1'b1;
    slowChain_next = slowOscTick ? slowChain_reg + 1'b1 : slowChain_reg;

    // Counting; a register write in the same cycle overrides it below
    if (run_reg && countTick) begin
      if (&count_reg) begin
        ovf_next = 1'b1;
        count_next = preload_reg;
        tone_next = ctrl_reg.toneEn ? !tone_reg : 1'b0;
        if (!ctrl_reg.reloadMode) begin
          run_next = 1'b0;
        end
      end else begin
        count_next = count_reg + 1'b1;
      end
    end
    if (!ctrl_reg.toneEn) begin
      tone_next = 1'b0;
    end

    if (doWrite) begin
      if (wInRange && wByte0_reg) begin
        case (wIdx)
          TMR_IDX_COUNT: begin
            preload_next = wData_reg[COUNT_W-1:0];
            count_next = wData_reg[COUNT_W-1:0];
          end
          TMR_IDX_CTRL: begin
            ctrl_next.clkSel = wData_reg[TMR_SEL_LSB +: 4];
            ctrl_next.reloadMode = wData_reg[TMR_RELOAD_BIT];
            ctrl_next.toneEn = wData_reg[TMR_TONE_BIT];
          end
          TMR_IDX_RUN: run_next = wData_reg[TMR_RUN_BIT];
          default: begin
          end
        endcase
      end
    end
  end

  always_comb begin
    rValid_next = rValid_reg;
    rResp_next = rResp_reg;
    rData_next = rData_reg;
    if (rValid_reg && s_axi_rready) begin
      rValid_next = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rValid_next = 1'b1;
      rResp_next = rInRange ? TMR_RESP_OKAY : TMR_RESP_DECERR;
      rData_next = 32'h0;
      if (rInRange) begin
        case (rIdx)
          TMR_IDX_COUNT: rData_next[COUNT_W-1:0] = count_reg;
          TMR_IDX_CTRL: begin
            rData_next[TMR_SEL_LSB +: 4] = ctrl_reg.clkSel;
            rData_next[TMR_RELOAD_BIT] = ctrl_reg.reloadMode;
            rData_next[TMR_TONE_BIT] = ctrl_reg.toneEn;
          end
          TMR_IDX_RUN: rData_next[TMR_RUN_BIT] = run_reg;
          default: rData_next = 32'h0;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      awAddr_reg <= '0;
      awHave_reg <= 1'b0;
      wData_reg <= 32'h0;
      wByte0_reg <= 1'b0;
      wHave_reg <= 1'b0;
      bValid_reg <= 1'b0;
      bResp_reg <= TMR_RESP_OKAY;
    end else begin
      awAddr_reg <= awAddr_next;
      awHave_reg <= awHave_next;
      wData_reg <= wData_next;
      wByte0_reg <= wByte0_next;
      wHave_reg <= wHave_next;
      bValid_reg <= bValid_next;
      bResp_reg <= bResp_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rValid_reg <= 1'b0;
      rResp_reg <= TMR_RESP_OKAY;
      rData_reg <= 32'h0;
    end else begin
      rValid_reg <= rValid_next;
      rResp_reg <= rResp_next;
      rData_reg <= rData_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_reg <= TMR_CTRL_RESET;
      run_reg <= 1'b0;
      count_reg <= '0;
      preload_reg <= '0;
      slowChain_reg <= '0;
      fastChain_reg <= '0;
      // Start high so a level already high at reset is not counted as an edge
      extPrev_reg <= 1'b1;
      tone_reg <= 1'b0;
      ovf_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      run_reg <= run_next;
      count_reg <= count_next;
      preload_reg <= preload_next;
      slowChain_reg <= slowChain_next;
      fastChain_reg <= fastChain_next;
      extPrev_reg <= extPrev_next;
      tone_reg <= tone_next;
      ovf_reg <= ovf_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  // One address and one data word are held at a time; no new ones until answered
  assign s_axi_awready = !awHave_reg && !bValid_reg;
  assign s_axi_wready = !wHave_reg && !bValid_reg;
  assign s_axi_bvalid = bValid_reg;
  assign s_axi_bresp = bResp_reg;
  assign s_axi_arready = !rValid_reg;
  assign s_axi_rvalid = rValid_reg;
  assign s_axi_rresp = rResp_reg;
  assign s_axi_rdata = rData_reg;
  assign toneOutputFirst = tone_reg;
  assign counterOverflow = ovf_reg;
endmodule

//--- testbench/tmr_first_timer_properties.sv
// Checker for bus answers and idle outputs of the first timer
`timescale 1ns/10ps
module tmr_first_timer_properties import tmr_pkg::*; #(
  parameter int COUNT_W = 8
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic slowOscTick,
  input wire logic externalCountInput,
  input wire logic toneOutputFirst,
  input wire logic counterOverflow,
  input wire logic [TMR_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [TMR_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ---------------------------------------------------------------------------
  // Handshake relations
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  wire arTake = s_axi_arvalid && s_axi_arready;
  wire arBad = s_axi_araddr > 8'hec || s_axi_araddr[1:0] != 2'h0;
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write not answered");
  a_read_answer: assert property (arTake |=> s_axi_rvalid)
    else $error("read not answered");
  a_resp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_far_decerr: assert property (arTake && arBad |=> s_axi_rresp == TMR_RESP_DECERR)
    else $error("bad read not refused");
  a_near_okay: assert property (arTake && !arBad |=> s_axi_rresp == TMR_RESP_OKAY)
    else $error("good read refused");
  a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  a_idle_reset: assert property ($past(sys_rst) |-> !s_axi_bvalid && !s_axi_rvalid
    && !toneOutputFirst && !counterOverflow) else $error("outputs not idle after reset");
  c_bad_read: cover property (arTake && arBad);
  c_overflow_tone: cover property (counterOverflow && toneOutputFirst);
  c_write_done: cover property (s_axi_bvalid && s_axi_bready);
endmodule

bind tmr_first_timer tmr_first_timer_properties #(.COUNT_W(COUNT_W)) tmr_first_timer_properties_inst (.*);

//--- testbench/tmr_first_timer_tb.sv
// Self-checking bench for the first timer registers and clock selection
`timescale 1ns/10ps
module tmr_first_timer_tb import tmr_pkg::*; ;
  logic clk_sys = 1'h0, sys_rst = 1'h1, slowOscTick = 1'h0, externalCountInput = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [TMR_ADDR_W-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic toneOutputFirst, counterOverflow;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int err_count = 0, checked = 0, seed = 32'hb987, cyc = 0, t;
  int mdl [0:2] = '{0, 8'h3e, 0};
  tmr_first_timer tmr_first_timer_inst (.*);
  // ---------------------------------------------------------------------------
  // Clock, external count source and reference model
  // ---------------------------------------------------------------------------
  initial forever #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc % 3 == 2) externalCountInput <= ~externalCountInput;
  end
  function automatic logic [1:0] resp(logic [7:0] a);
    return (a > 8'hec || a[1:0] != 2'h0) ? TMR_RESP_DECERR : TMR_RESP_OKAY;
  endfunction
  function automatic int per(int c);
    if (c < 2) return 6;
    if (c < 8) return c < 4 ? 16384 : 1 << (20 - 2 * c);
    return c < 15 ? 1 << (15 - c) : 1;
  endfunction
  task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string m);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask
  task automatic cmp_int(input int g, input int e, input string m);
    cmp(g, e, m);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1 && n < 50);
    s_axi_bready <= 1'h0;
    cmp(s_axi_bvalid, 1'h1, "bvalid");
    cmp(s_axi_bresp, resp(a), "bresp");
    if (resp(a) == TMR_RESP_OKAY && a < 8'h0c && s_axi_wstrb[0])
      mdl[a[3:2]] = d & (a == 8'h00 ? 8'hff : a == 8'h04 ? 8'h3f : 8'h01);
  endtask
  task automatic rd(input logic [7:0] a);
    int n = 0;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1 && n < 50);
    s_axi_rready <= 1'h0;
    cmp(s_axi_rvalid, 1'h1, "rvalid");
    cmp(s_axi_rresp, resp(a), "rresp");
    if (resp(a) == TMR_RESP_OKAY) cmp(s_axi_rdata, a < 8'h0c ? mdl[a[3:2]] : 0, "rdata");
  endtask
  task automatic wait_ovf(output int tt);
    int n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (counterOverflow !== 1'h1 && n < 40000);
    cmp(counterOverflow, 1'h1, "overflow");
    tt = cyc;
  endtask
  // Preload fe keeps overflow pulses apart at the undivided clock
  task automatic rate(input int c);
    int p, t1, t2;
    logic v1;
    p = c == 15 ? 254 : 255;
    wr(8'h08, 0);
    wr(8'h00, p);
    wr(8'h04, {c[0], 1'h1, c[3:0]});
    wr(8'h08, 1);
    wait_ovf(t1);
    v1 = toneOutputFirst;
    wait_ovf(t2);
    cmp_int(t2 - t1, per(c) * (256 - p), "gap");
    cmp(c[0] ? v1 ^ toneOutputFirst : toneOutputFirst, c[0], "tone");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ---------------------------------------------------------------------------
  // Test sequence and watchdog
  // ---------------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'h0;
    slowOscTick <= 1'h1;
    for (int i = 0; i < 4; i++) rd(i * 4);
    rd(8'h06);
    rd(8'hf0);
    rd(8'hec);
    $display("reset test done");
    repeat (4) begin
      s_axi_wstrb <= 4'($random(seed));
      wr(8'h00, $random(seed));
      wr(8'h04, $random(seed));
      wr(8'h40, $random(seed));
      wr(8'hf4, $random(seed));
      for (int i = 0; i < 3; i++) rd(i * 4);
    end
    s_axi_wstrb <= 4'hf;
    $display("register test done");
    for (int c = 0; c < 16; c++) rate(c);
    $display("clock select test done");
    wr(8'h08, 0);
    wr(8'h00, 8'hff);
    wr(8'h04, TMR_SEL_FAST);
    wr(8'h08, 1);
    wait_ovf(t);
    repeat (4) @(posedge clk_sys);
    mdl[2] = 0;
    rd(8'h08);
    rd(8'h00);
    $display("one shot test done");
    tally_and_finish;
  end
  initial begin
    repeat (100000) @(posedge clk_sys);
    err_count++;
    tally_and_finish;
  end
endmodule
